// [cfm_filter_mask_status.sv]
// Extended-ID acceptance mask, list sizes and priority-match status register
// What this block does
// - Received extended ID is ANDed with the 29-bit mask before comparison.
// - Mask resets to all ones in 29 bits, then it has no effect.
// - Status register updates on every priority-event filter element match whose index is below the active list size.
// - Status bit 15 gives list: 0 standard, 1 extended.
// - Status bits 14..8 give matching element index, below the list size.
// - Status bits 7..6 give storage outcome: none, lost, FIFO 0, FIFO 1.
// - Status bits 5..0 give FIFO element index, meaningful when bit 7 set.
// - Standard list size 0..128, larger values act as 128, bounding index.
// - Extended list size 0..64, larger values act as 64, bounding index.
module cfm_filter_mask_status (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [cfm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [cfm_pkg::EXT_ID_W-1:0] rx_ext_id,
  input wire logic [cfm_pkg::EXT_ID_W-1:0] filt_ext_id,
  output logic [cfm_pkg::EXT_ID_W-1:0] masked_ext_id,
  output logic ext_id_match,
  output logic [cfm_pkg::STD_SIZE_W-1:0] std_list_size,
  output logic [cfm_pkg::EXT_SIZE_W-1:0] ext_list_size,
  input wire logic prio_evt_valid,
  input wire cfm_pkg::cfm_prio_evt_t prio_evt
);
  import cfm_pkg::*;

  logic [EXT_ID_W-1:0] ext_id_mask_value_ff, nxt_ext_id_mask_value;
  logic [STD_SIZE_W-1:0] std_size_ff, nxt_std_size;
  logic [EXT_SIZE_W-1:0] ext_size_ff, nxt_ext_size;
  logic [START_ADDR_W-1:0] std_start_ff, nxt_std_start;
  logic [START_ADDR_W-1:0] ext_start_ff, nxt_ext_start;
  cfm_prio_evt_t prio_stat_ff, nxt_prio_stat;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [EXT_ID_W-1:0] masked_ff, nxt_masked;
  logic match_ff, nxt_match;
  logic evt_in_range;

  // Programmed sizes above the list capacity act as the capacity
  assign std_list_size = (std_size_ff > STD_SIZE_MAX) ? STD_SIZE_MAX : std_size_ff;
  assign ext_list_size = (ext_size_ff > EXT_SIZE_MAX) ? EXT_SIZE_MAX : ext_size_ff;

  // An index past the active list size cannot come from a real match, so it is dropped
  always_comb begin
    if (prio_evt.matched_list_select) begin
      evt_in_range = prio_evt.matched_element_index < ext_list_size;
    end else begin
      evt_in_range = {1'b0, prio_evt.matched_element_index} < std_list_size;
    end
  end

  // Register writes and status capture
  always_comb begin
    nxt_ext_id_mask_value = ext_id_mask_value_ff;
    nxt_std_size = std_size_ff;
    nxt_ext_size = ext_size_ff;
    nxt_std_start = std_start_ff;
    nxt_ext_start = ext_start_ff;
    nxt_prio_stat = prio_stat_ff;
    if (reg_wr) begin
      if (reg_addr == EXT_MASK_OFFSET) begin
        nxt_ext_id_mask_value = reg_wdata[EXT_ID_W-1:0];
      end else if (reg_addr == STD_CFG_OFFSET) begin
        nxt_std_size = reg_wdata[STD_SIZE_LSB +: STD_SIZE_W];
        nxt_std_start = reg_wdata[START_ADDR_LSB +: START_ADDR_W];
      end else if (reg_addr == EXT_CFG_OFFSET) begin
        nxt_ext_size = reg_wdata[EXT_SIZE_LSB +: EXT_SIZE_W];
        nxt_ext_start = reg_wdata[START_ADDR_LSB +: START_ADDR_W];
      end
    end
    // Status is read-only; hardware alone updates it
    if (prio_evt_valid && evt_in_range) begin
      nxt_prio_stat.matched_list_select = prio_evt.matched_list_select;
      nxt_prio_stat.matched_element_index = prio_evt.matched_element_index;
      nxt_prio_stat.storage_outcome = prio_evt.storage_outcome;
      // Index is cleared when no FIFO holds the message, so stale values never show
      if (prio_evt.storage_outcome[1]) begin
        nxt_prio_stat.fifo_element_index = prio_evt.fifo_element_index;
      end else begin
        nxt_prio_stat.fifo_element_index = 6'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_id_mask_value_ff <= EXT_MASK_RESET;
      std_size_ff <= STD_SIZE_RESET;
      ext_size_ff <= EXT_SIZE_RESET;
      std_start_ff <= START_ADDR_RESET;
      ext_start_ff <= START_ADDR_RESET;
      prio_stat_ff <= PRIO_STAT_RESET;
    end else begin
      ext_id_mask_value_ff <= nxt_ext_id_mask_value;
      std_size_ff <= nxt_std_size;
      ext_size_ff <= nxt_ext_size;
      std_start_ff <= nxt_std_start;
      ext_start_ff <= nxt_ext_start;
      prio_stat_ff <= nxt_prio_stat;
    end
  end

  // Read mux: unmapped offsets and reserved bits read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == EXT_MASK_OFFSET) begin
        nxt_rdata = {3'h0, ext_id_mask_value_ff};
      end else if (reg_addr == PRIO_STAT_OFFSET) begin
        nxt_rdata = {16'h0000, prio_stat_ff};
      end else if (reg_addr == STD_CFG_OFFSET) begin
        nxt_rdata = {8'h00, std_size_ff, std_start_ff, 2'h0};
      end else if (reg_addr == EXT_CFG_OFFSET) begin
        nxt_rdata = {9'h000, ext_size_ff, ext_start_ff, 2'h0};
      end
    end
  end

  // Mask path: don't-care bits drop out of both sides of the compare
  always_comb begin
    nxt_masked = rx_ext_id & ext_id_mask_value_ff;
    nxt_match = (nxt_masked == (filt_ext_id & ext_id_mask_value_ff));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h0000_0000;
      masked_ff <= {EXT_ID_W{1'b0}};
      match_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      masked_ff <= nxt_masked;
      match_ff <= nxt_match;
    end
  end

  assign reg_rdata = rdata_ff;
  assign masked_ext_id = masked_ff;
  assign ext_id_match = match_ff;

  property p_mask_and;
    @(posedge clk) disable iff (sys_rst)
      ##1 masked_ext_id == ($past(rx_ext_id) & $past(ext_id_mask_value_ff));
  endproperty
  a_mask_and: assert property (p_mask_and) else $error("masked id not rx id AND mask");

  property p_mask_write;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == EXT_MASK_OFFSET) ##1 reg_rd && reg_addr == EXT_MASK_OFFSET
      |=> reg_rdata == {3'h0, $past(reg_wdata[EXT_ID_W-1:0], 2)};
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask readback differs from write");

  property p_dont_care;
    @(posedge clk) disable iff (sys_rst)
      ((rx_ext_id ^ filt_ext_id) & ext_id_mask_value_ff) == {EXT_ID_W{1'b0}} |=> ext_id_match;
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("masked-off difference broke match");

  property p_stat_update;
    @(posedge clk) disable iff (sys_rst)
      prio_evt_valid && evt_in_range |=> prio_stat_ff.matched_list_select ==
        $past(prio_evt.matched_list_select) && prio_stat_ff.matched_element_index ==
        $past(prio_evt.matched_element_index);
  endproperty
  a_stat_update: assert property (p_stat_update) else $error("status list or index not captured");

  property p_outcome;
    @(posedge clk) disable iff (sys_rst)
      prio_evt_valid && evt_in_range |=> prio_stat_ff.storage_outcome == $past(prio_evt.storage_outcome);
  endproperty
  a_outcome: assert property (p_outcome) else $error("storage outcome not captured");

  property p_fifo_idx;
    @(posedge clk) disable iff (sys_rst)
      !prio_stat_ff.storage_outcome[1] |-> prio_stat_ff.fifo_element_index == 6'h00;
  endproperty
  a_fifo_idx: assert property (p_fifo_idx) else $error("fifo index set without FIFO storage");

  property p_stat_hold;
    @(posedge clk) disable iff (sys_rst)
      !(prio_evt_valid && evt_in_range) |=> $stable(prio_stat_ff);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status changed without an event");

  property p_std_bound;
    @(posedge clk) disable iff (sys_rst)
      std_list_size <= STD_SIZE_MAX && (std_size_ff <= STD_SIZE_MAX || std_list_size == STD_SIZE_MAX);
  endproperty
  a_std_bound: assert property (p_std_bound) else $error("standard list size not clamped");

  property p_ext_bound;
    @(posedge clk) disable iff (sys_rst)
      ext_list_size <= EXT_SIZE_MAX && (ext_size_ff <= EXT_SIZE_MAX || ext_list_size == EXT_SIZE_MAX);
  endproperty
  a_ext_bound: assert property (p_ext_bound) else $error("extended list size not clamped");

  property p_idx_reject;
    @(posedge clk) disable iff (sys_rst)
      prio_evt_valid && prio_evt.matched_list_select &&
        prio_evt.matched_element_index >= ext_list_size |=> $stable(prio_stat_ff);
  endproperty
  a_idx_reject: assert property (p_idx_reject) else $error("out-of-range index stored");

  property p_stat_read;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == PRIO_STAT_OFFSET |=> reg_rdata == {16'h0000, $past(prio_stat_ff)};
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read data wrong");

  // No reset guard here: the first edge after release must already see the all-ones mask
  property p_mask_reset;
    @(posedge clk) $fell(sys_rst) |-> ext_id_mask_value_ff == EXT_MASK_RESET;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask reset value wrong");

  property p_mask_rd;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == EXT_MASK_OFFSET |=>
        reg_rdata == {3'h0, $past(ext_id_mask_value_ff)};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read data wrong");

  property p_ones_pass;
    @(posedge clk) disable iff (sys_rst)
      ext_id_mask_value_ff == EXT_MASK_RESET |=>
        ext_id_match == ($past(rx_ext_id) == $past(filt_ext_id));
  endproperty
  a_ones_pass: assert property (p_ones_pass) else $error("full mask altered match");

  property p_mismatch;
    @(posedge clk) disable iff (sys_rst)
      ((rx_ext_id ^ filt_ext_id) & ext_id_mask_value_ff) != {EXT_ID_W{1'b0}} |=>
        !ext_id_match;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("unmasked difference matched");

  property p_std_pass;
    @(posedge clk) disable iff (sys_rst)
      std_size_ff <= STD_SIZE_MAX |-> std_list_size == std_size_ff;
  endproperty
  a_std_pass: assert property (p_std_pass) else $error("standard size altered");

  property p_ext_pass;
    @(posedge clk) disable iff (sys_rst)
      ext_size_ff <= EXT_SIZE_MAX |-> ext_list_size == ext_size_ff;
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("extended size altered");

  property p_std_reject;
    @(posedge clk) disable iff (sys_rst)
      prio_evt_valid && !prio_evt.matched_list_select &&
        {1'b0, prio_evt.matched_element_index} >= std_list_size |=> $stable(prio_stat_ff);
  endproperty
  a_std_reject: assert property (p_std_reject) else $error("late std index stored");

  property p_stat_wr;
    @(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == PRIO_STAT_OFFSET && !prio_evt_valid |=> $stable(prio_stat_ff);
  endproperty
  a_stat_wr: assert property (p_stat_wr) else $error("status took a bus write");

  property p_fifo_keep;
    @(posedge clk) disable iff (sys_rst)
      prio_evt_valid && evt_in_range && prio_evt.storage_outcome[1] |=>
        prio_stat_ff.fifo_element_index == $past(prio_evt.fifo_element_index);
  endproperty
  a_fifo_keep: assert property (p_fifo_keep) else $error("fifo index not captured");

  property p_list_bit;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == PRIO_STAT_OFFSET |=>
        reg_rdata[15] == $past(prio_stat_ff.matched_list_select) &&
        reg_rdata[31:16] == 16'h0000;
  endproperty
  a_list_bit: assert property (p_list_bit) else $error("list bit misplaced");

  property p_idx_field;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == PRIO_STAT_OFFSET |=>
        reg_rdata[14:8] == $past(prio_stat_ff.matched_element_index);
  endproperty
  a_idx_field: assert property (p_idx_field) else $error("index field misplaced");

  property p_outcome_field;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == PRIO_STAT_OFFSET |=>
        reg_rdata[7:6] == $past(prio_stat_ff.storage_outcome);
  endproperty
  a_outcome_field: assert property (p_outcome_field) else $error("outcome misplaced");

  property p_std_read;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == STD_CFG_OFFSET |=>
        reg_rdata[STD_SIZE_LSB +: STD_SIZE_W] == $past(std_size_ff);
  endproperty
  a_std_read: assert property (p_std_read) else $error("standard size read wrong");

  property p_ext_read;
    @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == EXT_CFG_OFFSET |=>
        reg_rdata[EXT_SIZE_LSB +: EXT_SIZE_W] == $past(ext_size_ff);
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("extended size read wrong");

  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");

  c_fifo1: cover property (@(posedge clk) disable iff (sys_rst)
    prio_evt_valid && evt_in_range && prio_evt.storage_outcome == CFM_IN_FIFO1);
  c_ext_list: cover property (@(posedge clk) disable iff (sys_rst)
    prio_evt_valid && evt_in_range && prio_evt.matched_list_select);
  c_masked_match: cover property (@(posedge clk) disable iff (sys_rst)
    ext_id_match && ext_id_mask_value_ff != EXT_MASK_RESET);
  c_idx_drop: cover property (@(posedge clk) disable iff (sys_rst)
    prio_evt_valid && !evt_in_range);
  c_wr_then_rd: cover property (@(posedge clk) disable iff (sys_rst)
    reg_wr ##1 reg_rd);
endmodule

// [cfm_filter_mask_status_tb.sv]
// Self-checking bench for the extended mask and priority status block
module cfm_filter_mask_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [EXT_ID_W-1:0] rx_ext_id = 29'h0, filt_ext_id = 29'h0, masked_ext_id, exp_m;
  logic [EXT_ID_W-1:0] mask_sh = EXT_MASK_RESET;
  logic ext_id_match, exp_hit, prio_evt_valid;
  logic rd_pend = 1'b0, chk_on = 1'b0, evt_req = 1'b0;
  logic [STD_SIZE_W-1:0] std_list_size;
  logic [EXT_SIZE_W-1:0] ext_list_size;
  cfm_prio_evt_t prio_evt, evt_in = PRIO_STAT_RESET, st_sh = PRIO_STAT_RESET;
  logic [31:0] exp_q[$];
  int miscompares = 0, total_checks = 0, cycles = 0;

  cfm_filter_mask_status u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_ext_id(rx_ext_id), .filt_ext_id(filt_ext_id), .masked_ext_id(masked_ext_id),
    .ext_id_match(ext_id_match), .std_list_size(std_list_size),
    .ext_list_size(ext_list_size), .prio_evt_valid(prio_evt_valid), .prio_evt(prio_evt));
  cfm_rx_model u_model (.clk(clk), .sys_rst(sys_rst), .evt_req(evt_req), .evt_in(evt_in),
    .prio_evt_valid(prio_evt_valid), .prio_evt(prio_evt));

  initial forever #5 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == EXT_MASK_OFFSET) mask_sh <= d[EXT_ID_W-1:0];
  endtask

  // Write then read back with no gap between the strobes
  task automatic wr_rb(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    if (a == EXT_MASK_OFFSET) mask_sh <= d[EXT_ID_W-1:0];
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Expected data is queued here and taken off by the monitor when it appears
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Sizes 5 and 3 are the last ones programmed before events are sent
  task automatic ev(input logic l, input logic [6:0] ix, input logic [1:0] o,
                    input logic [5:0] f);
    @(posedge clk);
    evt_req <= 1'b1;
    evt_in <= {l, ix, o, f};
    @(posedge clk);
    evt_req <= 1'b0;
    if (ix < (l ? 7'd3 : 7'd5)) st_sh <= {l, ix, o, o[1] ? f : 6'h0};
    @(posedge clk);
    rd(PRIO_STAT_OFFSET, {16'h0, st_sh});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
    if (chk_on) begin
      chk({3'h0, masked_ext_id}, {3'h0, exp_m});
      chk({31'h0, ext_id_match}, {31'h0, exp_hit});
      if (rd_pend) chk(reg_rdata, exp_q.pop_front());
      else chk(reg_rdata, 32'h0);
    end
    exp_m = rx_ext_id & mask_sh;
    exp_hit = ((rx_ext_id ^ filt_ext_id) & mask_sh) == '0;
    rd_pend = reg_rd;
  end

  initial begin
    logic [EXT_ID_W-1:0] r;
    logic [7:0] s;
    logic [6:0] e;
    logic [31:0] d;
    void'($urandom(32'hd186c28d));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_on <= 1'b1;
    rd(EXT_MASK_OFFSET, 32'h1fffffff);
    rd(PRIO_STAT_OFFSET, 32'h0);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        d = $urandom();
        wr_rb(EXT_MASK_OFFSET, d, {3'h0, d[EXT_ID_W-1:0]});
      end
      r = EXT_ID_W'($urandom());
      @(posedge clk);
      rx_ext_id <= r;
      filt_ext_id <= i[0] ? r ^ (EXT_ID_W'($urandom()) & ~mask_sh) : EXT_ID_W'($urandom());
    end
    wr(EXT_MASK_OFFSET, 32'hffffffff);
    rd(EXT_MASK_OFFSET, 32'h1fffffff);
    wr(PRIO_STAT_OFFSET, 32'h0000ffff);
    rd(PRIO_STAT_OFFSET, 32'h0);
    for (int k = 0; k < 4; k++) begin
      s = (k == 0) ? 8'd0 : (k == 1) ? 8'd128 : (k == 2) ? 8'd200 : 8'd5;
      e = (k == 0) ? 7'd0 : (k == 1) ? 7'd64 : (k == 2) ? 7'd100 : 7'd3;
      d = {8'h00, s, 14'($urandom()), 2'b00};
      wr(STD_CFG_OFFSET, d);
      #1 chk({24'h0, std_list_size}, {24'h0, (s > 8'd128) ? 8'd128 : s});
      rd(STD_CFG_OFFSET, d);
      d = {9'h000, e, 14'($urandom()), 2'b00};
      wr(EXT_CFG_OFFSET, d);
      #1 chk({25'h0, ext_list_size}, {25'h0, (e > 7'd64) ? 7'd64 : e});
      rd(EXT_CFG_OFFSET, d);
    end
    for (int k = 0; k < 8; k++) begin
      ev(k[0], k[0] ? 7'd2 : 7'd4, k[2:1], 6'($urandom()));
    end
    ev(1'b0, 7'd5, 2'b11, 6'h15);
    ev(1'b1, 7'd3, 2'b10, 6'h2a);
    ev(1'b1, 7'd0, 2'b11, 6'h3f);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule

// [cfm_pkg.sv]
// Package with register map, field layout and event types of the CAN filter mask/status block
package cfm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STD_CFG_OFFSET = 8'h84;
  localparam logic [ADDR_W-1:0] EXT_CFG_OFFSET = 8'h88;
  localparam logic [ADDR_W-1:0] EXT_MASK_OFFSET = 8'h90;
  localparam logic [ADDR_W-1:0] PRIO_STAT_OFFSET = 8'h94;

  localparam int unsigned EXT_ID_W = 29;
  localparam logic [EXT_ID_W-1:0] EXT_MASK_RESET = 29'h1fffffff;

  localparam int unsigned STD_SIZE_LSB = 16;
  localparam int unsigned STD_SIZE_W = 8;
  localparam int unsigned EXT_SIZE_LSB = 16;
  localparam int unsigned EXT_SIZE_W = 7;
  localparam int unsigned START_ADDR_LSB = 2;
  localparam int unsigned START_ADDR_W = 14;
  localparam logic [STD_SIZE_W-1:0] STD_SIZE_MAX = 8'h80;
  localparam logic [EXT_SIZE_W-1:0] EXT_SIZE_MAX = 7'h40;
  localparam logic [STD_SIZE_W-1:0] STD_SIZE_RESET = 8'h00;
  localparam logic [EXT_SIZE_W-1:0] EXT_SIZE_RESET = 7'h00;
  localparam logic [START_ADDR_W-1:0] START_ADDR_RESET = 14'h0000;

  typedef enum logic [1:0] {
    CFM_NO_FIFO,
    CFM_FIFO_LOST,
    CFM_IN_FIFO0,
    CFM_IN_FIFO1
  } cfm_outcome_t;

  // Packed in the exact bit order of the status word, bits 15 down to 0
  typedef struct packed {
    logic matched_list_select;
    logic [6:0] matched_element_index;
    cfm_outcome_t storage_outcome;
    logic [5:0] fifo_element_index;
  } cfm_prio_evt_t;

  localparam cfm_prio_evt_t PRIO_STAT_RESET = 16'h0000;
endpackage

// [cfm_rx_model.sv]
// Receive-side filter engine model that raises priority-match events
module cfm_rx_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic evt_req,
  input wire cfm_pkg::cfm_prio_evt_t evt_in,
  output logic prio_evt_valid,
  output cfm_pkg::cfm_prio_evt_t prio_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfm_pkg::*;
  // Event bus toggles outside a pulse, so a design that ignores valid is caught
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prio_evt_valid <= 1'b0;
      prio_evt <= PRIO_STAT_RESET;
    end else if (evt_req) begin
      prio_evt_valid <= 1'b1;
      prio_evt <= evt_in;
    end else begin
      prio_evt_valid <= 1'b0;
      prio_evt <= ~prio_evt;
    end
  end
endmodule
